// [design/odt_async_mode_control.sv]
// Behaviour
// - Frozen DLL in power-down selects asynchronous mode.
// - Asynchronous mode ignores additive latency.
// - Async turn-on between 2 and 8.5 ns.
// - Async turn-off between 2 and 8.5 ns.
// - ODT receiver stays active in power-down.
// - Frozen DLL gives a power-down entry transition.
// - Transition starts WL-1 before CKE low.
// - Transition ends with minimum CKE-low interval.
// - Pending refresh extends transition to its end.
// - Start point excluded, end points included.
// - Turn-on in transition within async/sync bounds.
// - Turn-off in transition within async/sync bounds.
`timescale 1ns/1ps
module odt_async_mode_control
(
  // Clock and reset
  input  wire logic                        I_REF_CLK,
  input  wire logic                        I_RESET_N,
  // Pins as registered by the device
  input  wire logic                        I_ODT,
  input  wire logic                        I_CKE,
  // Decoded commands
  input  wire logic                        I_WRITE,
  input  wire logic                        I_WRITE_BL8,
  input  wire logic                        I_READ,
  // Mode settings and status
  input  wire logic                        I_DLL_ON,
  input  wire logic                        I_MR0_PPD_DLL,
  input  wire logic [oamc_pkg::LAT_W-1:0]  I_CWL,
  input  wire logic [oamc_pkg::LAT_W-1:0]  I_AL,
  input  wire logic                        I_REFRESH_BUSY,
  // Termination control and status
  output logic                             O_RTT_ON,
  output logic                             O_ASYNC_MODE,
  output logic                             O_TRANS_PERIOD,
  output logic                             O_HOLD_VIOL,
  output logic                             O_CMD_VIOL
);

  oamc_pkg::oamc_main_t st_ff;
  oamc_pkg::oamc_main_t nxt_st;

  logic                       freeze;
  logic                       cke_fall;
  logic                       odt_late;
  logic                       hold_viol;
  logic [oamc_pkg::LAT_W-1:0] sync_tap;
  logic [oamc_pkg::LAT_W-1:0] tap;

  // ==========================================================================
  // Tap of the ODT history for a latency of WL - 2 clocks
  // ==========================================================================
  function automatic logic [oamc_pkg::LAT_W-1:0] lat_tap
  (
    input logic [oamc_pkg::LAT_W-1:0] cwl,
    input logic [oamc_pkg::LAT_W-1:0] al
  );
    logic [oamc_pkg::LAT_W:0] wl;
    logic [oamc_pkg::LAT_W:0] lim;
    wl  = {1'b0, cwl} + {1'b0, al};
    lim = oamc_pkg::ODT_LAT_OFS + oamc_pkg::TAP_OFS;
    if (wl <= lim)
    begin
      lat_tap = oamc_pkg::TAP_ZERO;
    end
    else
    begin
      lat_tap = oamc_pkg::LAT_W'(wl - lim);
    end
  endfunction

  // ==========================================================================
  // Submodules
  // ==========================================================================
  oamc_odt_delay u_delay
  (
    .i_clk      (I_REF_CLK),
    .i_rst_n    (I_RESET_N),
    .i_odt      (I_ODT),
    .i_tap      (tap),
    .o_odt_late (odt_late)
  );

  oamc_odt_hold u_hold
  (
    .i_clk       (I_REF_CLK),
    .i_rst_n     (I_RESET_N),
    .i_odt       (I_ODT),
    .i_write     (I_WRITE),
    .i_write_bl8 (I_WRITE_BL8),
    .o_viol      (hold_viol)
  );

  // ==========================================================================
  // Response path selection
  // ==========================================================================
  // Leaving sync mode drops the pending pipeline onto the async tap, so every
  // edge sampled in the last WL-2 clocks lands between async and sync timing;
  // the sample WL-1 clocks back already left on sync timing.
  always_comb
  begin
    sync_tap = lat_tap(I_CWL, I_AL);
    if (st_ff.mode == oamc_pkg::OAMC_SYNC)
    begin
      tap = sync_tap;
    end
    else
    begin
      tap = oamc_pkg::ASYNC_TAP;
    end
  end

  // ==========================================================================
  // Mode state machine
  // ==========================================================================
  always_comb
  begin
    nxt_st          = st_ff;
    freeze          = I_DLL_ON && (I_MR0_PPD_DLL == oamc_pkg::PPD_DLL_FROZEN);
    cke_fall        = st_ff.cke_prev && !I_CKE;
    nxt_st.cke_prev = I_CKE;
    case (st_ff.mode)
      oamc_pkg::OAMC_SYNC:
      begin
        if (cke_fall && freeze)
        begin
          nxt_st.mode    = oamc_pkg::OAMC_TRANS;
          nxt_st.cke_cnt = oamc_pkg::TCKE_MIN_CYC - oamc_pkg::CNT_ONE;
        end
      end
      oamc_pkg::OAMC_TRANS:
      begin
        if (I_CKE || !freeze)
        begin
          nxt_st.mode = oamc_pkg::OAMC_SYNC;
        end
        else if (st_ff.cke_cnt != oamc_pkg::CNT_ZERO)
        begin
          nxt_st.cke_cnt = st_ff.cke_cnt - oamc_pkg::CNT_ONE;
        end
        else if (!I_REFRESH_BUSY)
        begin
          nxt_st.mode = oamc_pkg::OAMC_ASYNC;
        end
      end
      oamc_pkg::OAMC_ASYNC:
      begin
        if (I_CKE || !freeze)
        begin
          nxt_st.mode = oamc_pkg::OAMC_SYNC;
        end
      end
      default:
      begin
        nxt_st.mode = oamc_pkg::OAMC_SYNC;
      end
    endcase

    nxt_st.rtt_on    = odt_late;
    nxt_st.trans     = (nxt_st.mode == oamc_pkg::OAMC_TRANS);
    nxt_st.async_md  = (nxt_st.mode == oamc_pkg::OAMC_ASYNC);
    nxt_st.cmd_viol  = !st_ff.cke_prev && !I_CKE && (I_READ || I_WRITE);
    nxt_st.hold_viol = hold_viol;
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
    begin
      st_ff <= oamc_pkg::MAIN_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign O_RTT_ON       = st_ff.rtt_on;
  assign O_ASYNC_MODE   = st_ff.async_md;
  assign O_TRANS_PERIOD = st_ff.trans;
  assign O_HOLD_VIOL    = st_ff.hold_viol;
  assign O_CMD_VIOL     = st_ff.cmd_viol;

endmodule

// [include/oamc_pkg.sv]
package oamc_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned LAT_W   = 5;
  localparam int unsigned DEPTH   = 32;
  localparam int unsigned CNT_W   = 4;
  localparam int unsigned HOLD_W  = 3;

  // ==========================================================================
  // Clock and asynchronous termination timing
  // ==========================================================================
  localparam real CLK_PERIOD_NS   = 5.0;
  localparam real T_AONPD_MIN_NS  = 2.0;
  localparam real T_AONPD_MAX_NS  = 8.5;
  localparam real T_AOFPD_MIN_NS  = 2.0;
  localparam real T_AOFPD_MAX_NS  = 8.5;

  localparam int AONPD_MIN_CYC = int'($ceil(T_AONPD_MIN_NS / CLK_PERIOD_NS));
  localparam int AONPD_MAX_CYC = int'($floor(T_AONPD_MAX_NS / CLK_PERIOD_NS));
  localparam int AOFPD_MIN_CYC = int'($ceil(T_AOFPD_MIN_NS / CLK_PERIOD_NS));
  localparam int AOFPD_MAX_CYC = int'($floor(T_AOFPD_MAX_NS / CLK_PERIOD_NS));

  // One delay serves both edges: the later of the two minimums, at least 1
  localparam int ASYNC_DLY_CYC =
    (AONPD_MIN_CYC > AOFPD_MIN_CYC) ?
      ((AONPD_MIN_CYC < 1) ? 1 : AONPD_MIN_CYC) :
      ((AOFPD_MIN_CYC < 1) ? 1 : AOFPD_MIN_CYC);
  localparam logic [LAT_W-1:0] ASYNC_TAP = LAT_W'(ASYNC_DLY_CYC - 1);

  // ==========================================================================
  // Latency offsets (turn-on/off latency is WL - 2, entry lookback WL - 1)
  // ==========================================================================
  localparam logic [LAT_W:0]   ODT_LAT_OFS = 6'h02;
  localparam logic [LAT_W:0]   TAP_OFS     = 6'h01;
  localparam logic [LAT_W-1:0] TAP_ZERO    = 5'h00;

  // ==========================================================================
  // Hold minimums and power-down entry interval
  // ==========================================================================
  localparam logic [HOLD_W-1:0] ODT_HOLD_SHORT = 3'h4;
  localparam logic [HOLD_W-1:0] ODT_HOLD_LONG  = 3'h6;
  localparam logic [HOLD_W-1:0] HOLD_ONE       = 3'h1;
  localparam logic [HOLD_W-1:0] HOLD_ZERO      = 3'h0;
  localparam logic [CNT_W-1:0]  TCKE_MIN_CYC   = 4'h3;
  localparam logic [CNT_W-1:0]  CNT_ONE        = 4'h1;
  localparam logic [CNT_W-1:0]  CNT_ZERO       = 4'h0;

  // MR0 A12 value that freezes the DLL in precharge power-down
  localparam logic PPD_DLL_FROZEN = 1'b0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0]
  {
    OAMC_SYNC  = 2'b00,
    OAMC_TRANS = 2'b01,
    OAMC_ASYNC = 2'b11
  } oamc_mode_t;

  typedef struct packed
  {
    oamc_mode_t       mode;
    logic [CNT_W-1:0] cke_cnt;
    logic             cke_prev;
    logic             rtt_on;
    logic             trans;
    logic             async_md;
    logic             cmd_viol;
    logic             hold_viol;
  } oamc_main_t;

  localparam oamc_main_t MAIN_RST = '{
    mode:      OAMC_SYNC,
    cke_cnt:   CNT_ZERO,
    cke_prev:  1'b0,
    rtt_on:    1'b0,
    trans:     1'b0,
    async_md:  1'b0,
    cmd_viol:  1'b0,
    hold_viol: 1'b0
  };

  typedef struct packed
  {
    logic [DEPTH-1:0] hist;
  } oamc_dly_t;

  typedef struct packed
  {
    logic              odt_prev;
    logic [HOLD_W-1:0] rem;
    logic              viol;
  } oamc_hold_t;

endpackage

// [design/oamc_odt_delay.sv]
`timescale 1ns/1ps
module oamc_odt_delay
(
  // Clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  // Sampled ODT and selected latency tap
  input  wire logic                         i_odt,
  input  wire logic [oamc_pkg::LAT_W-1:0]   i_tap,
  // Delayed ODT
  output logic                              o_odt_late
);

  oamc_pkg::oamc_dly_t st_ff;
  oamc_pkg::oamc_dly_t nxt_st;

  // ==========================================================================
  // History of ODT samples, kept running in every power state
  // ==========================================================================
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.hist = {st_ff.hist[oamc_pkg::DEPTH-2:0], i_odt};
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_odt_late = st_ff.hist[i_tap];

endmodule

// [design/oamc_odt_hold.sv]
`timescale 1ns/1ps
module oamc_odt_hold
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Controller side samples
  input  wire logic i_odt,
  input  wire logic i_write,
  input  wire logic i_write_bl8,
  // Early ODT release seen
  output logic      o_viol
);

  oamc_pkg::oamc_hold_t st_ff;
  oamc_pkg::oamc_hold_t nxt_st;

  function automatic logic [oamc_pkg::HOLD_W-1:0] hold_max
  (
    input logic [oamc_pkg::HOLD_W-1:0] a,
    input logic [oamc_pkg::HOLD_W-1:0] b
  );
    hold_max = (a > b) ? a : b;
  endfunction

  logic [oamc_pkg::HOLD_W-1:0] dec;
  logic [oamc_pkg::HOLD_W-1:0] need;
  logic [oamc_pkg::HOLD_W-1:0] wr_hold;

  // ==========================================================================
  // Remaining high samples owed by the controller
  // ==========================================================================
  always_comb
  begin
    nxt_st   = st_ff;
    dec      = (st_ff.rem == oamc_pkg::HOLD_ZERO) ? oamc_pkg::HOLD_ZERO
                                                  : st_ff.rem - oamc_pkg::HOLD_ONE;
    wr_hold  = i_write_bl8 ? oamc_pkg::ODT_HOLD_LONG : oamc_pkg::ODT_HOLD_SHORT;
    need     = dec;
    if (i_odt && !st_ff.odt_prev)
    begin
      need = hold_max(need, oamc_pkg::ODT_HOLD_SHORT - oamc_pkg::HOLD_ONE);
    end
    if (i_odt && i_write)
    begin
      need = hold_max(need, wr_hold - oamc_pkg::HOLD_ONE);
    end
    nxt_st.rem      = i_odt ? need : oamc_pkg::HOLD_ZERO;
    nxt_st.odt_prev = i_odt;
    nxt_st.viol     = !i_odt && (st_ff.rem != oamc_pkg::HOLD_ZERO);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_viol = st_ff.viol;

endmodule

// [tb/oamc_ctrl_model.sv]
`timescale 1ns/1ps
module oamc_ctrl_model
(
  // Clock
  input  wire logic i_clk,
  // Controller pins and commands
  output logic      o_odt,
  output logic      o_cke,
  output logic      o_write,
  output logic      o_write_bl8,
  output logic      o_read
);
  initial
  begin
    o_odt = 1'b0;
    o_cke = 1'b1;
    o_write = 1'b0;
    o_write_bl8 = 1'b0;
    o_read = 1'b0;
  end

  // ODT high for lead samples, then n more high samples, the first of them with the write
  task automatic odt_pulse(input int lead, input int n, input logic wr, input logic bl8);
    @(negedge i_clk);
    o_odt = 1'b1;
    repeat (lead) @(negedge i_clk);
    o_write = wr;
    o_write_bl8 = bl8;
    @(negedge i_clk);
    o_write = 1'b0;
    repeat (n - 1) @(negedge i_clk);
    o_odt = 1'b0;
  endtask

  // Drives CKE only; read_cmd below can issue a read while CKE is low
  task automatic set_cke(input logic v);
    @(negedge i_clk);
    o_cke = v;
  endtask

  task automatic read_cmd();
    @(negedge i_clk);
    o_read = 1'b1;
    @(negedge i_clk);
    o_read = 1'b0;
  endtask
endmodule

// [tb/oamc_odt_checker.sv]
`timescale 1ns/1ps
module oamc_odt_checker
(
  // Clock and reset
  input wire logic                       I_REF_CLK,
  input wire logic                       I_RESET_N,
  // Inputs
  input wire logic                       I_ODT,
  input wire logic                       I_CKE,
  input wire logic                       I_WRITE,
  input wire logic                       I_WRITE_BL8,
  input wire logic                       I_READ,
  input wire logic                       I_DLL_ON,
  input wire logic                       I_MR0_PPD_DLL,
  input wire logic [oamc_pkg::LAT_W-1:0] I_CWL,
  input wire logic [oamc_pkg::LAT_W-1:0] I_AL,
  input wire logic                       I_REFRESH_BUSY,
  // Outputs
  input wire logic                       O_RTT_ON,
  input wire logic                       O_ASYNC_MODE,
  input wire logic                       O_TRANS_PERIOD,
  input wire logic                       O_HOLD_VIOL,
  input wire logic                       O_CMD_VIOL
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  wire sync_md = !O_ASYNC_MODE && !O_TRANS_PERIOD;
  wire fast_md = O_ASYNC_MODE || O_TRANS_PERIOD;

  sequence s_entry;
    !I_CKE && $past(I_CKE) && I_DLL_ON && !I_REFRESH_BUSY &&
      I_MR0_PPD_DLL == oamc_pkg::PPD_DLL_FROZEN;
  endsequence
  sequence s_settle;
    O_TRANS_PERIOD[*3] ##1 (O_ASYNC_MODE && !O_TRANS_PERIOD);
  endsequence

  chk_trans_len: assert property (s_entry |=> s_settle)
    else $error("entry transition length wrong");
  chk_refresh_hold: assert property (O_TRANS_PERIOD && I_REFRESH_BUSY && !I_CKE |=> O_TRANS_PERIOD)
    else $error("transition ended during refresh");
  chk_no_freeze: assert property ((I_MR0_PPD_DLL || !I_DLL_ON) && sync_md |=> sync_md)
    else $error("mode left sync without freeze");
  chk_exit_sync: assert property (fast_md && I_CKE |=> sync_md)
    else $error("no return to sync");
  chk_async_follow: assert property (fast_md && $past(fast_md) |-> O_RTT_ON == $past(I_ODT, 2))
    else $error("async termination delay wrong");
  chk_sync_lat: assert property (sync_md && $past(sync_md) && $past(sync_md, 2) &&
    $past(sync_md, 3) && $past(I_CWL) == 5'h05 && $past(I_AL) == 5'h00 |->
    O_RTT_ON == $past(I_ODT, 4))
    else $error("sync termination latency wrong");
  chk_cmd_viol: assert property ((I_READ || I_WRITE) && !I_CKE && !$past(I_CKE) |=> O_CMD_VIOL)
    else $error("command in power-down not flagged");
  chk_hold_short: assert property ($rose(I_ODT) ##[1:3] $fell(I_ODT) |-> ##2 O_HOLD_VIOL)
    else $error("short ODT hold not flagged");
  chk_hold_bc4: assert property (I_WRITE && !I_WRITE_BL8 && I_ODT ##1 I_ODT[*2] ##1 !I_ODT |-> ##2 O_HOLD_VIOL)
    else $error("short hold after BC4 write not flagged");
  chk_hold_bl8: assert property (I_WRITE && I_WRITE_BL8 && I_ODT ##1 I_ODT[*4] ##1 !I_ODT |-> ##2 O_HOLD_VIOL)
    else $error("short hold after BL8 write not flagged");
  chk_viol_cause: assert property (O_HOLD_VIOL |-> !$past(I_ODT, 2) && $past(I_ODT, 3))
    else $error("hold flag without ODT fall");
endmodule

bind odt_async_mode_control oamc_odt_checker i_oamc_odt_checker
(.I_REF_CLK, .I_RESET_N, .I_ODT, .I_CKE, .I_WRITE, .I_WRITE_BL8, .I_READ, .I_DLL_ON,
 .I_MR0_PPD_DLL, .I_CWL, .I_AL, .I_REFRESH_BUSY, .O_RTT_ON, .O_ASYNC_MODE,
 .O_TRANS_PERIOD, .O_HOLD_VIOL, .O_CMD_VIOL);

// [tb/test_odt_async_mode_control.sv]
`timescale 1ns/1ps
module test_odt_async_mode_control;
  logic                       clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic                       ppd = 1'b1;
  logic                       rfb = 1'b0;
  logic [oamc_pkg::LAT_W-1:0] al = 5'h00;
  logic [oamc_pkg::LAT_W-1:0] cwl = 5'h05;
  logic                       dll = 1'b1;
  logic                       odt, cke, wr, bl8, rd, rtt, asy, trn, hv, cv;
  int                         mismatches = 0;
  int                         check_count = 0;
  int                         cycles = 0;

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  oamc_ctrl_model i_oamc_ctrl_model
  (.i_clk(clk), .o_odt(odt), .o_cke(cke), .o_write(wr), .o_write_bl8(bl8), .o_read(rd));

  odt_async_mode_control i_odt_async_mode_control
  (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_ODT(odt), .I_CKE(cke), .I_WRITE(wr),
   .I_WRITE_BL8(bl8), .I_READ(rd), .I_DLL_ON(dll), .I_MR0_PPD_DLL(ppd), .I_CWL(cwl),
   .I_AL(al), .I_REFRESH_BUSY(rfb), .O_RTT_ON(rtt), .O_ASYNC_MODE(asy),
   .O_TRANS_PERIOD(trn), .O_HOLD_VIOL(hv), .O_CMD_VIOL(cv));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input string nm, input logic seen, input logic exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", nm, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic lat_check(input int lat);
    fork
      i_oamc_ctrl_model.odt_pulse(0, 6, 1'b0, 1'b0);
    join_none
    idle(lat + 1);
    check("rtt before latency", rtt, 1'b0);
    idle(1);
    check("rtt after latency", rtt, 1'b1);
    idle(5);
    check("rtt before turn-off", rtt, 1'b1);
    idle(1);
    check("rtt after turn-off", rtt, 1'b0);
    idle(6);
  endtask

  // Flag is caught anywhere in a short window after ODT falls
  task automatic hold_case(input int lead, input int n, input logic w, input logic b8,
                           input logic exp);
    logic seen;
    seen = 1'b0;
    i_oamc_ctrl_model.odt_pulse(lead, n, w, b8);
    repeat (3)
    begin
      @(negedge clk);
      seen = seen | hv;
    end
    check("hold violation", seen, exp);
    idle(4);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_hold();
    hold_case(0, 3, 1'b0, 1'b0, 1'b1);
    hold_case(0, 4, 1'b0, 1'b0, 1'b0);
    hold_case(0, 3, 1'b1, 1'b0, 1'b1);
    hold_case(0, 4, 1'b1, 1'b0, 1'b0);
    hold_case(2, 3, 1'b1, 1'b0, 1'b1);
    hold_case(2, 4, 1'b1, 1'b0, 1'b0);
    hold_case(0, 5, 1'b1, 1'b1, 1'b1);
    hold_case(0, 6, 1'b1, 1'b1, 1'b0);
    hold_case(2, 5, 1'b1, 1'b1, 1'b1);
    $display("test hold done");
  endtask

  task automatic t_sync();
    lat_check(3);
    al = 5'h02;
    idle(8);
    lat_check(5);
    al = 5'h00;
    cwl = 5'h06;
    idle(8);
    lat_check(4);
    cwl = 5'h05;
    idle(8);
    $display("test sync done");
  endtask

  task automatic t_entry(input logic busy);
    ppd = oamc_pkg::PPD_DLL_FROZEN;
    rfb = busy;
    idle(2);
    i_oamc_ctrl_model.set_cke(1'b0);
    idle(1);
    check("transition start", trn, 1'b1);
    idle(3);
    check("transition end", trn, busy);
    check("async entry", asy, ~busy);
    rfb = 1'b0;
    idle(3);
    check("async after refresh", asy, 1'b1);
    lat_check(1);
    i_oamc_ctrl_model.read_cmd();
    check("command violation", cv, 1'b1);
    i_oamc_ctrl_model.set_cke(1'b1);
    idle(1);
    check("sync after exit", asy | trn, 1'b0);
    idle(8);
    $display("test entry done");
  endtask

  task automatic t_nofreeze(input logic p, input logic d);
    ppd = p;
    dll = d;
    i_oamc_ctrl_model.set_cke(1'b0);
    repeat (5)
    begin
      idle(1);
      check("no async without freeze", asy | trn, 1'b0);
    end
    i_oamc_ctrl_model.set_cke(1'b1);
    idle(4);
    $display("test no freeze done");
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      results();
    end
  end

  initial
  begin
    idle(2);
    rst_n = 1'b1;
    idle(2);
    t_hold();
    t_sync();
    t_entry(1'b0);
    t_entry(1'b1);
    t_nofreeze(~oamc_pkg::PPD_DLL_FROZEN, 1'b1);
    t_nofreeze(oamc_pkg::PPD_DLL_FROZEN, 1'b0);
    results();
  end
endmodule
